/* src/rws_defines.svh */
// Register indices, field positions, reset values and timing counts of
// the reset and watchdog sequencer. Included by its bare name.
`ifndef RWS_DEFINES_SVH
`define RWS_DEFINES_SVH
// Register indices; the byte address is four times the index.
`define RWS_IDX_STATUS 8'h03
`define RWS_IDX_CAUSE  8'h8E
`define RWS_IDX_CFG    8'h40
`define RWS_IDX_OPT    8'h41
`define RWS_IDX_STATE  8'h42
`define RWS_IDX_WDT    8'h43
// Field positions.
`define RWS_ST_TO      4
`define RWS_ST_PD      3
`define RWS_PC_POR     1
`define RWS_PC_BOR     0
// Reset values.
`define RWS_STATUS_POR 8'h18
`define RWS_CAUSE_POR  2'h0
`define RWS_CFG_RST    8'h9B
`define RWS_OPT_RST    4'hF
`define RWS_VEC_RESET  13'h0000
`define RWS_VEC_IRQ    13'h0004
// Times in their own units and the counts derived from them.
`define RWS_CLK_NS      5
`define RWS_LFOSC_HZ    31000
`define RWS_WDT_BASE_US 17000
`define RWS_POWERUP_TIMER_US     64000
`define RWS_BROWNOUT_MIN_DURATION_NS     100
`define RWS_OST_PERIODS 1024
`define RWS_WDT_BASE_TICKS \
  ((`RWS_WDT_BASE_US * `RWS_LFOSC_HZ) / 1000000)
`define RWS_POWERUP_TIMER_TICKS \
  ((`RWS_POWERUP_TIMER_US * `RWS_LFOSC_HZ) / 1000000)
`define RWS_BROWNOUT_MIN_DURATION_CYC \
  ((`RWS_BROWNOUT_MIN_DURATION_NS + `RWS_CLK_NS - 1) / `RWS_CLK_NS)
`endif

/* src/rws_pkg.sv */
// Types shared by the reset and watchdog sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package rws_pkg;
  typedef enum logic [2:0] {
    CM_CRYSTAL_LOW  = 3'h0,
    CM_CRYSTAL_MID  = 3'h1,
    CM_CRYSTAL_HIGH = 3'h2,
    CM_EXT_RC       = 3'h3,
    CM_INTERNAL_OSC = 3'h4,
    CM_EXT_CLOCK    = 3'h5
  } rws_clk_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD  = 3'h0,
    ST_POWERUP_TIMER  = 3'h1,
    ST_OST   = 3'h2,
    ST_RUN   = 3'h3,
    ST_SLEEP = 3'h4,
    ST_WAKE  = 3'h5
  } rws_state_t;

  typedef struct packed {
    rws_clk_mode_t clk_mode;
    logic [1:0]    brownout_enable_field;
    logic          brownout_level_select;
    logic          powerup_timer_cfg;
    logic          wdt_en;
  } rws_cfg_t;

  typedef struct packed {
    logic       prescaler_assign;
    logic [2:0] ps;
  } rws_opt_t;
endpackage : rws_pkg

/* src/rws_sequencer.sv */
// Reset sequencer, brown-out filter, watchdog and reset-cause flags.
// Assumes ticks of the 31 kHz and system oscillators arrive as one-cycle
// pulses on clk_i, and the supply comparators as synchronous levels.
// How it works
// - Watchdog counts ticks of the 31 kHz oscillator, not the system clock.
// - One 8-bit prescaler; assign bit and 3-bit ratio set the period.
// - Period runs from 17 ms at 1:1 to about 2.2 s at 1:128.
// - Start-up timer borrows the watchdog counter; watchdog held meanwhile.
// - With the enable bit set the watchdog runs and software cannot stop it.
// - Cleared when disabled, by clear instruction, on RC-type sleep exit.
// - After crystal-mode wake-up the watchdog stays clear until start-up ends.
// - Brown-out mode field: 11 always, 10 not in sleep, 0X off.
// - One bit picks one of two brown-out trip points.
// - Supply below the trip for the minimum duration resets the device.
// - Brown-out during the power-up timer restarts it after recovery.
// - Flash erase forces brown-out detection on at the lowest trip.
// - Power-up timer follows power-on; start-up timer follows power-up timer.
// - Time-outs run regardless of the reset pin; its release starts at once.
// - Crystal modes add 1024 oscillator periods; others only power-up delay.
// - External clock with power-up timer disabled gives no time-out.
// - Cause bit 0 clears on brown-out; software sets it to watch.
// - Cause bit 1 clears on power-on only; software writes it to 1.
// - Interrupt wake-up with global enable loads the interrupt vector.
// - Pin and watchdog resets apply their own status values.
// - Power-up timer holds reset 64 ms, on watchdog oscillator ticks.
// - Power-up timer config bit set disables it, clear enables it.
// - Time-out and power-down flags tell the reset source apart.
//
// Design decision made here: the Wishbone register port.
`include "rws_defines.svh"

module rws_sequencer #(
  parameter int ADR_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             lf_tick_i,
  input  wire logic             osc_tick_i,
  input  wire logic             por_i,
  input  wire logic             vdd_below_lo_i,
  input  wire logic             vdd_below_hi_i,
  input  wire logic             external_reset_pin_n_i,
  input  wire logic             flash_erase_i,
  input  wire logic             clear_watchdog_instr_i,
  input  wire logic             sleep_instr_i,
  input  wire logic             irq_wake_i,
  input  wire logic             global_irq_enable_i,
  output logic                  sys_reset_o,
  output logic                  sleeping_o,
  output logic                  wake_o,
  output logic                  pc_load_o,
  output logic      [12:0]      pc_load_addr_o
);

  function automatic logic is_crystal(rws_pkg::rws_clk_mode_t m);
    return (m == rws_pkg::CM_CRYSTAL_LOW) ||
           (m == rws_pkg::CM_CRYSTAL_MID) ||
           (m == rws_pkg::CM_CRYSTAL_HIGH);
  endfunction

  function automatic logic [7:0] ratio_m1(logic [2:0] ps);
    return (8'h01 << ps) - 8'h01;
  endfunction

  rws_pkg::rws_state_t state;
  rws_pkg::rws_state_t next_state;
  rws_pkg::rws_cfg_t   cfg;
  rws_pkg::rws_opt_t   opt;
  logic                cfg_locked;
  logic [7:0]          status;
  logic [7:0]          next_status;
  logic [1:0]          cause;
  logic [1:0]          next_cause;
  logic [10:0]         ripple;
  logic [10:0]         next_ripple;
  logic [7:0]          presc;
  logic [10:0]         powerup_timer_cnt;
  logic [7:0]          bor_cnt;
  logic                pin_low_q;
  logic                wake_irq;

  // Bus decode.
  wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [7:0]  idx      = wb_adr_i[9:2];
  wire        wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire        wr_stat  = wr_lane0 && (idx == `RWS_IDX_STATUS);
  wire        wr_cause = wr_lane0 && (idx == `RWS_IDX_CAUSE);
  wire        wr_cfg   = wr_lane0 && (idx == `RWS_IDX_CFG);
  wire        wr_opt   = wr_lane0 && (idx == `RWS_IDX_OPT);
  wire [31:0] rd_data  =
    (idx == `RWS_IDX_STATUS) ? {24'h000000, status} :
    (idx == `RWS_IDX_CAUSE)  ? {30'h00000000, cause} :
    (idx == `RWS_IDX_CFG)    ? {24'h000000, cfg} :
    (idx == `RWS_IDX_OPT)    ? {28'h0000000, opt} :
    (idx == `RWS_IDX_STATE)  ? {26'h0000000, cfg_locked, sleeping_o,
                                sys_reset_o, state} :
    (idx == `RWS_IDX_WDT)    ? {13'h0000, presc, ripple} :
                               32'h00000000;

  // State groups.
  wire crystal  = is_crystal(cfg.clk_mode);
  wire pin_low  = ~external_reset_pin_n_i;
  wire in_run   = (state == rws_pkg::ST_RUN);
  wire in_sleep = (state == rws_pkg::ST_SLEEP);
  wire in_ost   = (state == rws_pkg::ST_OST) ||
                  (state == rws_pkg::ST_WAKE);

  // Brown-out detection.
  wire bor_on   = flash_erase_i ||
                  (cfg.brownout_enable_field == 2'h3) ||
                  ((cfg.brownout_enable_field == 2'h2) && !in_sleep);
  wire below    = flash_erase_i ? vdd_below_lo_i :
                  (cfg.brownout_level_select ? vdd_below_lo_i : vdd_below_hi_i);
  wire bor_low  = bor_on & below;
  wire bor_hit  = bor_low &&
                  (bor_cnt == 8'(`RWS_BROWNOUT_MIN_DURATION_CYC - 1));
  wire hold     = por_i | bor_low;

  // Timer expiries.
  wire powerup_timer_done = lf_tick_i &&
                   (powerup_timer_cnt == 11'(`RWS_POWERUP_TIMER_TICKS - 1));
  wire ost_done  = in_ost && osc_tick_i &&
                   (ripple == 11'(`RWS_OST_PERIODS - 1));
  wire wdt_run   = (in_run | in_sleep) & cfg.wdt_en;
  wire base_done = wdt_run && lf_tick_i &&
                   (ripple == 11'(`RWS_WDT_BASE_TICKS - 1));
  wire wdt_to    = base_done &&
                   (!opt.prescaler_assign || (presc == ratio_m1(opt.ps)));

  // Events that change the flags.
  wire ev_bor      = bor_hit & ~por_i &
                     (state != rws_pkg::ST_HOLD);
  wire ev_pin_run  = in_run & pin_low & ~pin_low_q;
  wire ev_pin_slp  = (in_sleep | (state == rws_pkg::ST_WAKE)) &
                     pin_low;
  wire ev_wdt_rst  = in_run & wdt_to & ~pin_low;
  wire ev_wdt_wake = in_sleep & wdt_to & ~pin_low;
  wire ev_irq_wake = in_sleep & irq_wake_i & ~wdt_to & ~pin_low;
  wire ev_sleep    = in_run & sleep_instr_i & ~pin_low & ~wdt_to;
  wire ev_clear_watchdog_instr   = in_run & clear_watchdog_instr_i & ~pin_low;
  wire wake_req    = ev_wdt_wake | ev_irq_wake;
  wire exit_rc     = wake_req & ~crystal;
  wire wake_done   = (exit_rc || ((state == rws_pkg::ST_WAKE) &&
                     ost_done && !pin_low)) && !por_i && !bor_hit;
  wire wdt_clr     = !cfg.wdt_en || ev_clear_watchdog_instr || ev_sleep ||
                     exit_rc || pin_low || !(in_run | in_sleep);

  // Sequencer.
  always_comb begin
    next_state = state;
    case (state)
      rws_pkg::ST_HOLD: begin
        if (!hold) begin
          if (!cfg.powerup_timer_cfg) begin
            next_state = rws_pkg::ST_POWERUP_TIMER;
          end else if (crystal) begin
            next_state = rws_pkg::ST_OST;
          end else begin
            next_state = rws_pkg::ST_RUN;
          end
        end
      end
      rws_pkg::ST_POWERUP_TIMER: begin
        if (powerup_timer_done) begin
          next_state = crystal ? rws_pkg::ST_OST
                               : rws_pkg::ST_RUN;
        end
      end
      rws_pkg::ST_OST: begin
        if (ost_done) begin
          next_state = rws_pkg::ST_RUN;
        end
      end
      rws_pkg::ST_RUN: begin
        if (ev_sleep) begin
          next_state = rws_pkg::ST_SLEEP;
        end
      end
      rws_pkg::ST_SLEEP: begin
        if (ev_pin_slp || exit_rc) begin
          next_state = rws_pkg::ST_RUN;
        end else if (wake_req) begin
          next_state = rws_pkg::ST_WAKE;
        end
      end
      rws_pkg::ST_WAKE: begin
        if (ev_pin_slp || ost_done) begin
          next_state = rws_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = rws_pkg::ST_HOLD;
      end
    endcase
    if (por_i || bor_hit) begin
      next_state = rws_pkg::ST_HOLD;
    end
  end

  // The start-up count and the watchdog base share one ripple counter,
  // so the watchdog is necessarily idle while the oscillator settles.
  always_comb begin
    next_ripple = 11'h000;
    if (in_ost) begin
      next_ripple = ripple + 11'(osc_tick_i);
      if (ost_done) begin
        next_ripple = 11'h000;
      end
    end else if (!wdt_clr && lf_tick_i) begin
      next_ripple = base_done ? 11'h000 : ripple + 11'h001;
    end else if (!wdt_clr) begin
      next_ripple = ripple;
    end
  end

  // Flags: hardware events come last so they win over a software write.
  always_comb begin
    next_status = status;
    next_cause  = cause;
    if (wr_stat) begin
      next_status[7:5] = wb_dat_i[7:5];
      next_status[2:0] = wb_dat_i[2:0];
    end
    if (wr_cause) begin
      next_cause = wb_dat_i[1:0];
    end
    if (ev_clear_watchdog_instr) begin
      next_status[`RWS_ST_TO] = 1'b1;
      next_status[`RWS_ST_PD] = 1'b1;
    end
    if (ev_sleep) begin
      next_status[`RWS_ST_TO] = 1'b1;
      next_status[`RWS_ST_PD] = 1'b0;
    end
    if (ev_pin_run) begin
      next_status[7:5] = 3'h0;
    end
    if (ev_pin_slp) begin
      next_status[7:5] = 3'h0;
      next_status[`RWS_ST_TO] = 1'b1;
      next_status[`RWS_ST_PD] = 1'b0;
    end
    if (ev_wdt_rst) begin
      next_status[7:5] = 3'h0;
      next_status[`RWS_ST_TO] = 1'b0;
      next_status[`RWS_ST_PD] = 1'b1;
    end
    if (ev_wdt_wake) begin
      next_status[`RWS_ST_TO] = 1'b0;
      next_status[`RWS_ST_PD] = 1'b0;
    end
    if (ev_irq_wake) begin
      next_status[`RWS_ST_TO] = 1'b1;
      next_status[`RWS_ST_PD] = 1'b0;
    end
    if (ev_bor) begin
      next_status[7:3] = 5'h03;
      next_cause[`RWS_PC_BOR] = 1'b0;
    end
    if (por_i) begin
      next_status = `RWS_STATUS_POR;
      next_cause  = `RWS_CAUSE_POR;
    end
  end

  // Merged reset: time-outs, pin and a one-cycle watchdog reset.
  wire next_busy  = (next_state == rws_pkg::ST_HOLD) ||
                    (next_state == rws_pkg::ST_POWERUP_TIMER) ||
                    (next_state == rws_pkg::ST_OST);
  wire next_rst   = next_busy | pin_low | ev_wdt_rst;
  wire rst_leave  = sys_reset_o & ~next_rst;
  wire vec_load   = wake_done & (wake_irq | ev_irq_wake) &
                    global_irq_enable_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= rws_pkg::ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= `RWS_STATUS_POR;
      cause  <= `RWS_CAUSE_POR;
    end else begin
      status <= next_status;
      cause  <= next_cause;
    end
  end

  // Configuration takes one write after reset and is then frozen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg        <= rws_pkg::rws_cfg_t'(`RWS_CFG_RST);
      cfg_locked <= 1'b0;
      opt        <= rws_pkg::rws_opt_t'(`RWS_OPT_RST);
    end else begin
      if (wr_cfg && !cfg_locked) begin
        cfg        <= rws_pkg::rws_cfg_t'(wb_dat_i[7:0]);
        cfg_locked <= 1'b1;
      end
      if (wr_opt) begin
        opt <= rws_pkg::rws_opt_t'(wb_dat_i[3:0]);
      end
    end
  end

  // Watchdog ripple counter and shared prescaler.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ripple <= 11'h000;
      presc  <= 8'h00;
    end else begin
      ripple <= next_ripple;
      if (wdt_clr || !opt.prescaler_assign || wdt_to) begin
        presc <= 8'h00;
      end else if (base_done) begin
        presc <= presc + 8'h01;
      end
    end
  end

  // Power-up timer and brown-out duration filter.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      powerup_timer_cnt <= 11'h000;
      bor_cnt  <= 8'h00;
    end else begin
      if (state != rws_pkg::ST_POWERUP_TIMER) begin
        powerup_timer_cnt <= 11'h000;
      end else if (lf_tick_i) begin
        powerup_timer_cnt <= powerup_timer_cnt + 11'h001;
      end
      if (!bor_low) begin
        bor_cnt <= 8'h00;
      end else if (!bor_hit) begin
        bor_cnt <= bor_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_low_q <= 1'b0;
      wake_irq  <= 1'b0;
    end else begin
      pin_low_q <= pin_low;
      if (ev_irq_wake) begin
        wake_irq <= 1'b1;
      end else if (wake_req || wake_done || !in_ost) begin
        wake_irq <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_o    <= 1'b1;
      sleeping_o     <= 1'b0;
      wake_o         <= 1'b0;
      pc_load_o      <= 1'b0;
      pc_load_addr_o <= `RWS_VEC_RESET;
    end else begin
      sys_reset_o <= next_rst;
      sleeping_o  <= (next_state == rws_pkg::ST_SLEEP) ||
                     (next_state == rws_pkg::ST_WAKE);
      wake_o      <= wake_done;
      pc_load_o   <= rst_leave | vec_load;
      if (rst_leave) begin
        pc_load_addr_o <= `RWS_VEC_RESET;
      end else if (vec_load) begin
        pc_load_addr_o <= `RWS_VEC_IRQ;
      end
    end
  end

  // Classic bus: every access is answered one cycle after strobe.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_data;
      end
    end
  end

endmodule // rws_sequencer

/* tb/rws_seq_sva.sv */
// Port checker for the reset and watchdog sequencer, bound to it.
// Assumes one clock and a synchronous, active-high reset.
`include "rws_defines.svh"

module rws_seq_sva (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  input wire logic        por_i,
  input wire logic        external_reset_pin_n_i,
  input wire logic        sleep_instr_i,
  input wire logic        sys_reset_o,
  input wire logic        sleeping_o,
  input wire logic        wake_o,
  input wire logic        pc_load_o,
  input wire logic [12:0] pc_load_addr_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  ack_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus acknowledge longer than one cycle");
  ack_cause_a: assert property (
    $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("bus acknowledge without a request");
  por_hold_a: assert property (por_i |=> sys_reset_o)
    else $error("power-on request did not hold the core in reset");
  pin_hold_a: assert property (
    !external_reset_pin_n_i |=> sys_reset_o)
    else $error("low reset pin did not reset the core");
  pin_release_a: assert property (
    $fell(sys_reset_o) |-> external_reset_pin_n_i)
    else $error("core left reset while the pin was low");
  reset_vec_a: assert property (
    pc_load_o && !wake_o |-> pc_load_addr_o == `RWS_VEC_RESET)
    else $error("reset start address wrong");
  irq_vec_a: assert property (
    wake_o && pc_load_o |-> pc_load_addr_o == `RWS_VEC_IRQ)
    else $error("interrupt wake address wrong");
  sleep_entry_a: assert property (
    sleep_instr_i && !sys_reset_o && !sleeping_o && !por_i
      && external_reset_pin_n_i |=> sleeping_o)
    else $error("sleep instruction did not enter sleep");
  wake_pulse_a: assert property (
    wake_o |-> $past(sleeping_o) ##1 !wake_o)
    else $error("wake pulse malformed or not from sleep");

  cover property (wake_o && pc_load_o);
  cover property ($fell(sys_reset_o));
  cover property ($rose(sys_reset_o) && !por_i);
endmodule // rws_seq_sva

bind rws_sequencer rws_seq_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .por_i(por_i),
  .external_reset_pin_n_i(external_reset_pin_n_i),
  .sleep_instr_i(sleep_instr_i), .sys_reset_o(sys_reset_o),
  .sleeping_o(sleeping_o), .wake_o(wake_o), .pc_load_o(pc_load_o),
  .pc_load_addr_o(pc_load_addr_o)
);

/* tb/rws_supply_model.sv */
// Model of the supply monitors, reset pin and oscillator ticks.
// Assumes the bench steers it through four command levels.
module rws_supply_model (
  input  wire logic clk_i,
  input  wire logic sag_i,
  input  wire logic deep_i,
  input  wire logic pin_hold_i,
  input  wire logic tick_en_i,
  output logic      por_o,
  output logic      below_lo_o,
  output logic      below_hi_o,
  output logic      pin_n_o,
  output logic      lf_tick_o,
  output logic      osc_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] por_cnt;
  // A sag crosses only the upper trip; a deep sag crosses both trips.
  assign below_hi_o = sag_i | deep_i;
  assign below_lo_o = deep_i;
  assign pin_n_o    = ~pin_hold_i;
  // The power-on pulse outlasts the bench reset by a few cycles.
  assign por_o      = (por_cnt != 4'hC);
  initial begin
    por_cnt    = 4'h0;
    lf_tick_o  = 1'b0;
    osc_tick_o = 1'b0;
  end
  always @(posedge clk_i) begin
    if (por_cnt != 4'hC) por_cnt <= por_cnt + 4'h1;
    // Slow ticks every cycle keep the long counts short in simulation.
    lf_tick_o  <= tick_en_i;
    osc_tick_o <= tick_en_i & ~osc_tick_o;
  end
endmodule // rws_supply_model

/* tb/tb.sv */
// Self-checking bench of the reset and watchdog sequencer.
// Assumes classic Wishbone registers and the supply model beside it.
`include "rws_defines.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [9:0]  adr = 10'h000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat;
  logic        sag = 1'b0, pin_low = 1'b0, tick_en = 1'b0;
  logic        deep = 1'b0, ers = 1'b0;
  logic        clr = 1'b0, slp = 1'b0, irq = 1'b0, global_irq_enable = 1'b0;
  logic        por, blo, bhi, pin_n, lf, osc, ack, srst;
  logic        sleeping, wake, pcl;
  logic [12:0] pca;
  int          err_count = 0, cmp_count = 0;

  rws_supply_model u_model (.clk_i(clk_i), .sag_i(sag), .deep_i(deep),
    .pin_hold_i(pin_low), .tick_en_i(tick_en), .por_o(por),
    .below_lo_o(blo), .below_hi_o(bhi), .pin_n_o(pin_n),
    .lf_tick_o(lf), .osc_tick_o(osc));
  rws_sequencer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .lf_tick_i(lf),
    .osc_tick_i(osc), .por_i(por), .vdd_below_lo_i(blo),
    .vdd_below_hi_i(bhi), .external_reset_pin_n_i(pin_n),
    .flash_erase_i(ers), .clear_watchdog_instr_i(clr),
    .sleep_instr_i(slp), .irq_wake_i(irq), .global_irq_enable_i(global_irq_enable),
    .sys_reset_o(srst), .sleeping_o(sleeping), .wake_o(wake),
    .pc_load_o(pcl), .pc_load_addr_o(pca));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, m, got,
               exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp, input string m);
    chk({31'h0, got}, {31'h0, exp}, m);
  endtask

  // Entered just after a rising edge; ack and read data are taken at the
  // rising edge that samples ack high, and only then is the request let go.
  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= {idx, 2'b00};
    dat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    chkb(ack, 1'b1, "bus answer");
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 32'h0, q);
    chk(q, exp, "register read");
  endtask

  task automatic wait_rst(input logic lvl, input int lim, output int n);
    n = 0;
    while (srst !== lvl && n < lim) begin
      @(negedge clk_i);
      n++;
    end
    chkb(srst, lvl, "core reset level");
    @(posedge clk_i);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    complete_run();
  end

  initial begin
    int n;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst(1'b0, 50, n);
    rd(`RWS_IDX_STATUS, `RWS_STATUS_POR);
    rd(`RWS_IDX_CAUSE, 32'h00);
    rd(`RWS_IDX_CFG, `RWS_CFG_RST);
    rd(`RWS_IDX_OPT, `RWS_OPT_RST);
    rd(8'h50, 32'h00);
    wr(`RWS_IDX_CAUSE, 32'h03);
    rd(`RWS_IDX_CAUSE, 32'h03);
    wr(`RWS_IDX_STATUS, 32'hFF);
    rd(`RWS_IDX_STATUS, 32'hFF);
    wr(`RWS_IDX_STATUS, 32'h00);
    rd(`RWS_IDX_STATUS, 32'h18);
    wr(`RWS_IDX_OPT, 32'h00);
    tick_en <= 1'b1;
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wait_rst(1'b1, 2000, n);
    tick_en <= 1'b0;
    chkb(n > 515 && n < 545, 1'b1, "watchdog period");
    wait_rst(1'b0, 50, n);
    rd(`RWS_IDX_STATUS, 32'h08);
    rd(`RWS_IDX_CAUSE, 32'h03);
    slp <= 1'b1;
    @(posedge clk_i);
    slp <= 1'b0;
    @(negedge clk_i);
    chkb(sleeping, 1'b1, "sleep entry");
    @(posedge clk_i);
    rd(`RWS_IDX_STATUS, 32'h10);
    global_irq_enable <= 1'b1;
    irq <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    chkb(wake, 1'b1, "wake pulse");
    chkb(pcl, 1'b1, "vector load on wake");
    chk({19'h0, pca}, {19'h0, `RWS_VEC_IRQ}, "wake address");
    @(posedge clk_i);
    irq <= 1'b0;
    global_irq_enable <= 1'b0;
    sag <= 1'b1;
    repeat (10) @(posedge clk_i);
    sag <= 1'b0;
    repeat (3) @(negedge clk_i);
    chkb(srst, 1'b0, "short sag ignored");
    @(posedge clk_i);
    sag <= 1'b1;
    repeat (25) @(posedge clk_i);
    sag <= 1'b0;
    chkb(srst, 1'b1, "long sag resets");
    wait_rst(1'b0, 100, n);
    rd(`RWS_IDX_CAUSE, 32'h02);
    rd(`RWS_IDX_STATUS, 32'h18);
    pin_low <= 1'b1;
    repeat (3) @(posedge clk_i);
    chkb(srst, 1'b1, "pin reset");
    pin_low <= 1'b0;
    wait_rst(1'b0, 5, n);
    rd(`RWS_IDX_STATUS, 32'h18);
    rd(`RWS_IDX_CAUSE, 32'h02);
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst(1'b0, 50, n);
    // Crystal mode, power-up timer on, watchdog off.
    wr(`RWS_IDX_CFG, 32'h18);
    wr(`RWS_IDX_CFG, `RWS_CFG_RST);
    rd(`RWS_IDX_CFG, 32'h18);
    pin_low <= 1'b1;
    tick_en <= 1'b1;
    sag <= 1'b1;
    repeat (25) @(posedge clk_i);
    sag <= 1'b0;
    repeat (1000) @(posedge clk_i);
    rd(`RWS_IDX_STATE, 32'h29);
    repeat (1500) @(posedge clk_i);
    rd(`RWS_IDX_STATE, 32'h2A);
    repeat (2500) @(posedge clk_i);
    chkb(srst, 1'b1, "pin holds after time-outs");
    pin_low <= 1'b0;
    wait_rst(1'b0, 3, n);
    n = 0;
    repeat (700) begin
      @(negedge clk_i);
      if (srst !== 1'b0) n++;
    end
    chkb(n == 0, 1'b1, "disabled watchdog stays quiet");
    // Internal oscillator, brown-out disabled, watchdog off.
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rst(1'b0, 50, n);
    wr(`RWS_IDX_CFG, 32'h82);
    sag <= 1'b1;
    ers <= 1'b1;
    repeat (25) @(posedge clk_i);
    chkb(srst, 1'b0, "erase watches the low trip only");
    ers <= 1'b0;
    deep <= 1'b1;
    repeat (25) @(posedge clk_i);
    chkb(srst, 1'b0, "disabled brown-out ignores sag");
    ers <= 1'b1;
    repeat (25) @(posedge clk_i);
    chkb(srst, 1'b1, "erase forces brown-out on");
    ers <= 1'b0;
    deep <= 1'b0;
    sag <= 1'b0;
    wait_rst(1'b0, 50, n);
    complete_run();
  end
endmodule // tb
